/* rtl/rtc_core.sv */
// BCD timekeeper with calibration, read hold and test output pin
`timescale 1ns/1ps
module rtc_core #(
  parameter int HOLD_CYCLES = rtc_pkg::HOLD_CYCLES_DEF,
  parameter logic [6:0] SLAVE_ADDR = rtc_pkg::SLAVE_ADDR_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Crystal
  input wire logic osc_pin,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Test and level pin, open drain
  output logic test_level_out,
  output logic test_level_oe
);
  import rtc_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Step a BCD count; anything at or past the last value wraps
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    logic [8:0] res;
    if (v >= last) begin
      res = {1'b1, first};
    end else if (v[3:0] >= UNIT_MAX) begin
      res = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      res = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return res;
  endfunction

  // Last date of the month; years divisible by four are leap years
  function automatic logic [7:0] month_end(input logic [7:0] mon,
                                           input logic [7:0] yr);
    logic leap;
    logic [7:0] res;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    if (mon == MON_FEB) begin
      res = leap ? DAYS_29 : DAYS_28;
    end else if (mon == MON_APR || mon == MON_JUN ||
                 mon == MON_SEP || mon == MON_NOV) begin
      res = DAYS_30;
    end else begin
      res = DAYS_31;
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic osc_halt;
    logic [7:0] sec;
    logic [7:0] min;
    logic century_roll_enable;
    logic century_flag;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] ctrl;
    logic [5:0] cal_min;
    logic [HOLD_W-1:0] hold_cnt;
    logic [TIME_REGS-1:0][7:0] vis;
    logic pin_oe;
  } rtc_s;

  rtc_s r_reg, r_next;

  logic sec_tick;
  logic test_wave;
  logic cal_now;
  logic [2:0] reg_ptr;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic rd_active;
  logic [TIME_REGS-1:0][7:0] live;

  // ---------------------------------------------------------------
  // Divider and serial port
  // ---------------------------------------------------------------
  osc_divider u_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .osc_pin(osc_pin),
    .osc_halt(r_reg.osc_halt),
    .cal_now(cal_now),
    .cal_speed_up(r_reg.ctrl[SIGN_BIT]),
    .sec_tick(sec_tick),
    .test_wave(test_wave)
  );

  serial_slave #(.SLAVE_ADDR(SLAVE_ADDR)) u_port (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_ptr(reg_ptr),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .rd_active(rd_active)
  );

  // ---------------------------------------------------------------
  // Calibration window and register image
  // ---------------------------------------------------------------
  // Corrected second is second 00 of each of the first 2N minutes
  assign cal_now = (r_reg.sec == BCD_ZERO) &&
                   (r_reg.cal_min < {r_reg.ctrl[4:0], 1'b0});

  always_comb begin
    live[ADDR_SEC] = {r_reg.osc_halt, r_reg.sec[6:0]};
    live[ADDR_MIN] = r_reg.min & MIN_MASK;
    live[ADDR_HOUR] = {r_reg.century_roll_enable, r_reg.century_flag,
                       r_reg.hour[5:0]};
    live[ADDR_WDAY] = r_reg.wday & WDAY_MASK;
    live[ADDR_DATE] = r_reg.date & DATE_MASK;
    live[ADDR_MONTH] = r_reg.month & MONTH_MASK;
    live[ADDR_YEAR] = r_reg.year;
  end

  // Control is read directly; time bytes come from the held copy
  assign rd_data = (reg_ptr == ADDR_CTRL) ? r_reg.ctrl
                                          : r_reg.vis[reg_ptr];

  // ---------------------------------------------------------------
  // Counting, writes, read hold, pin
  // ---------------------------------------------------------------
  always_comb begin
    logic [8:0] st;
    logic [7:0] mlast;
    logic hold;
    st = '0;
    hold = 1'b0;
    mlast = month_end(r_reg.month, r_reg.year);
    r_next = r_reg;
    if (sec_tick) begin
      st = bcd_step(r_reg.sec, SEC_LAST, BCD_ZERO);
      r_next.sec = st[7:0];
      if (st[8]) begin
        st = bcd_step(r_reg.min, SEC_LAST, BCD_ZERO);
        r_next.min = st[7:0];
        // Six bits wrap at 64 minutes by themselves
        r_next.cal_min = r_reg.cal_min + 6'h01;
        if (st[8]) begin
          st = bcd_step(r_reg.hour, HOUR_LAST, BCD_ZERO);
          r_next.hour = st[7:0];
          if (st[8]) begin
            st = bcd_step(r_reg.wday, WDAY_LAST, BCD_ONE);
            r_next.wday = st[7:0];
            st = bcd_step(r_reg.date, mlast, BCD_ONE);
            r_next.date = st[7:0];
            if (st[8]) begin
              st = bcd_step(r_reg.month, MONTH_LAST, BCD_ONE);
              r_next.month = st[7:0];
              if (st[8]) begin
                st = bcd_step(r_reg.year, YEAR_LAST, BCD_ZERO);
                r_next.year = st[7:0];
                if (st[8] && r_reg.century_roll_enable) begin
                  r_next.century_flag = ~r_reg.century_flag;
                end
              end
            end
          end
        end
      end
    end
    // A write overrides the tick for the byte written
    if (wr_stb) begin
      unique case (reg_ptr)
        ADDR_SEC: begin
          r_next.osc_halt = wr_data[HALT_BIT];
          r_next.sec = wr_data & SEC_MASK;
        end
        ADDR_MIN: r_next.min = wr_data & MIN_MASK;
        ADDR_HOUR: begin
          r_next.century_roll_enable = wr_data[CENT_EN_BIT];
          r_next.century_flag = wr_data[CENT_FLAG_BIT];
          r_next.hour = wr_data & HOUR_MASK;
        end
        ADDR_WDAY: r_next.wday = wr_data & WDAY_MASK;
        ADDR_DATE: r_next.date = wr_data & DATE_MASK;
        ADDR_MONTH: r_next.month = wr_data & MONTH_MASK;
        ADDR_YEAR: r_next.year = wr_data;
        ADDR_CTRL: r_next.ctrl = wr_data;
      endcase
    end
    // Held copy stays still while a time byte is being read, but
    // never longer than the hold time; the true count keeps running
    hold = rd_active && (reg_ptr < ADDR_CTRL) &&
           (r_reg.hold_cnt < HOLD_W'(HOLD_CYCLES - 1));
    if (rd_active && (reg_ptr < ADDR_CTRL)) begin
      r_next.hold_cnt = r_reg.hold_cnt + (hold ? 1'b1 : 1'b0);
    end else begin
      r_next.hold_cnt = '0;
    end
    if (!hold) begin
      r_next.vis = live;
    end
    // Open drain: enable means pulling low
    if (r_reg.ctrl[TEST_SEL_BIT]) begin
      r_next.pin_oe = ~test_wave;
    end else begin
      r_next.pin_oe = ~r_reg.ctrl[OUT_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_reg <= '{wday: BCD_ONE, date: BCD_ONE, month: BCD_ONE,
                 ctrl: CTRL_RST, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign test_level_out = 1'b0;
  assign test_level_oe = r_reg.pin_oe;
endmodule

/* rtl/rtc_pkg.sv */
// Shared constants and types of the BCD real-time clock
package rtc_pkg;
  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_SEC = 3'h0;
  localparam logic [2:0] ADDR_MIN = 3'h1;
  localparam logic [2:0] ADDR_HOUR = 3'h2;
  localparam logic [2:0] ADDR_WDAY = 3'h3;
  localparam logic [2:0] ADDR_DATE = 3'h4;
  localparam logic [2:0] ADDR_MONTH = 3'h5;
  localparam logic [2:0] ADDR_YEAR = 3'h6;
  localparam logic [2:0] ADDR_CTRL = 3'h7;
  localparam int TIME_REGS = 7;
  // ---------------------------------------------------------------
  // Field positions and write masks
  // ---------------------------------------------------------------
  localparam int HALT_BIT = 7;
  localparam int CENT_EN_BIT = 7;
  localparam int CENT_FLAG_BIT = 6;
  localparam int OUT_BIT = 7;
  localparam int TEST_SEL_BIT = 6;
  localparam int SIGN_BIT = 5;
  localparam logic [7:0] SEC_MASK = 8'h7F;
  localparam logic [7:0] MIN_MASK = 8'h7F;
  localparam logic [7:0] HOUR_MASK = 8'h3F;
  localparam logic [7:0] WDAY_MASK = 8'h07;
  localparam logic [7:0] DATE_MASK = 8'h3F;
  localparam logic [7:0] MONTH_MASK = 8'h1F;
  localparam logic [7:0] CAL_MASK = 8'h1F;
  // ---------------------------------------------------------------
  // BCD limits, month codes, reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] UNIT_MAX = 4'h9;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] SEC_LAST = 8'h59;
  localparam logic [7:0] HOUR_LAST = 8'h23;
  localparam logic [7:0] WDAY_LAST = 8'h07;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [7:0] CTRL_RST = 8'h80;
  // ---------------------------------------------------------------
  // Oscillator and calibration timing
  // ---------------------------------------------------------------
  localparam int OSC_HZ = 32768;
  localparam int TEST_HZ = 512;
  localparam int SHORT_CYC = 128;
  localparam int LONG_CYC = 256;
  localparam int CAL_CYCLE_MIN = 64;
  localparam logic [15:0] SEC_NORM = 16'(OSC_HZ);
  localparam logic [15:0] SEC_SHORT = 16'(OSC_HZ - SHORT_CYC);
  localparam logic [15:0] SEC_LONG = 16'(OSC_HZ + LONG_CYC);
  localparam logic [4:0] TEST_HALF = 5'(OSC_HZ / (2 * TEST_HZ) - 1);
  // ---------------------------------------------------------------
  // Core clock and read-hold time
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int HOLD_MS = 250;
  localparam int HOLD_CYCLES_DEF = HOLD_MS * (CLK_HZ / 1000);
  localparam int HOLD_W = 23;
  // Bus address of the slave; the value is arbitrary
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h50;
  // ---------------------------------------------------------------
  // Serial port states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SP_IDLE, SP_RX, SP_ACK, SP_TX, SP_MACK
  } sport_state_e;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} sport_phase_e;
endpackage

/* rtl/osc_divider.sv */
// Crystal divider producing second ticks, calibration and test wave
`timescale 1ns/1ps
module osc_divider (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Crystal pin
  input wire logic osc_pin,
  // Control from the timekeeper
  input wire logic osc_halt,
  input wire logic cal_now,
  input wire logic cal_speed_up,
  // Results
  output logic sec_tick,
  output logic test_wave
);
  import rtc_pkg::*;

  typedef struct packed {
    logic osc_s1;
    logic osc_s2;
    logic osc_d;
    logic [15:0] sec_cnt;
    logic [4:0] test_cnt;
    logic test_wave;
    logic sec_tick;
  } div_s;

  div_s r_reg, r_next;
  logic [15:0] limit;

  always_comb begin
    r_next = r_reg;
    r_next.osc_s1 = osc_pin;
    r_next.osc_s2 = r_reg.osc_s1;
    r_next.osc_d = r_reg.osc_s2;
    r_next.sec_tick = 1'b0;
    // One second per corrected minute is cut or stretched here
    limit = SEC_NORM;
    if (cal_now) begin
      limit = cal_speed_up ? SEC_SHORT : SEC_LONG;
    end
    if (r_reg.osc_s2 && !r_reg.osc_d && !osc_halt) begin
      // Test wave counts raw crystal edges, ahead of the correction
      if (r_reg.test_cnt == TEST_HALF) begin
        r_next.test_cnt = '0;
        r_next.test_wave = ~r_reg.test_wave;
      end else begin
        r_next.test_cnt = r_reg.test_cnt + 5'h01;
      end
      // Compare with >= so a limit that drops mid-second cannot skip
      if (r_reg.sec_cnt >= limit - 16'h0001) begin
        r_next.sec_cnt = '0;
        r_next.sec_tick = 1'b1;
      end else begin
        r_next.sec_cnt = r_reg.sec_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sec_tick = r_reg.sec_tick;
  assign test_wave = r_reg.test_wave;
endmodule

/* rtl/serial_slave.sv */
// Two-wire serial slave with auto-incrementing register pointer
`timescale 1ns/1ps
module serial_slave #(
  parameter logic [6:0] SLAVE_ADDR = rtc_pkg::SLAVE_ADDR_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Register side
  output logic [2:0] reg_ptr,
  output logic wr_stb,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  output logic rd_active
);
  import rtc_pkg::*;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    sport_state_e st;
    sport_phase_e ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [2:0] ptr;
    logic rw;
    logic oe;
    logic wr_stb;
    logic [7:0] wr_data;
  } sport_s;

  sport_s r_reg, r_next;
  logic scl_rise, scl_fall, start_c, stop_c;

  always_comb begin
    scl_rise = r_reg.scl_s2 && !r_reg.scl_d;
    scl_fall = !r_reg.scl_s2 && r_reg.scl_d;
    start_c = r_reg.scl_s2 && r_reg.scl_d && !r_reg.sda_s2 && r_reg.sda_d;
    stop_c = r_reg.scl_s2 && r_reg.scl_d && r_reg.sda_s2 && !r_reg.sda_d;
    r_next = r_reg;
    r_next.scl_s1 = scl_in;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_d = r_reg.scl_s2;
    r_next.sda_s1 = sda_in;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_d = r_reg.sda_s2;
    r_next.wr_stb = 1'b0;
    if (start_c) begin
      r_next.st = SP_RX;
      r_next.ph = PH_ADDR;
      r_next.cnt = '0;
      r_next.oe = 1'b0;
    end else if (stop_c) begin
      r_next.st = SP_IDLE;
      r_next.oe = 1'b0;
    end else begin
      unique case (r_reg.st)
        SP_IDLE: begin
        end
        SP_RX: begin
          if (scl_rise) begin
            r_next.sh = {r_reg.sh[6:0], r_reg.sda_s2};
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (scl_fall && r_reg.cnt[3]) begin
            r_next.cnt = '0;
            r_next.oe = 1'b1;
            r_next.st = SP_ACK;
            unique case (r_reg.ph)
              PH_ADDR: begin
                r_next.rw = r_reg.sh[0];
                if (r_reg.sh[7:1] != SLAVE_ADDR) begin
                  r_next.oe = 1'b0;
                  r_next.st = SP_IDLE;
                end
              end
              PH_PTR: r_next.ptr = r_reg.sh[2:0];
              PH_DATA: begin
                r_next.wr_stb = 1'b1;
                r_next.wr_data = r_reg.sh;
              end
            endcase
          end
        end
        SP_ACK: begin
          if (scl_fall) begin
            r_next.oe = 1'b0;
            r_next.st = SP_RX;
            if (r_reg.ph == PH_ADDR && r_reg.rw) begin
              r_next.st = SP_TX;
              r_next.sh = rd_data;
              r_next.oe = ~rd_data[7];
              r_next.cnt = 4'h1;
            end else if (r_reg.ph == PH_ADDR) begin
              r_next.ph = PH_PTR;
            end else if (r_reg.ph == PH_PTR) begin
              r_next.ph = PH_DATA;
            end else begin
              r_next.ptr = r_reg.ptr + 3'h1;
            end
          end
        end
        SP_TX: begin
          if (scl_fall) begin
            if (r_reg.cnt[3]) begin
              r_next.oe = 1'b0;
              r_next.cnt = '0;
              r_next.st = SP_MACK;
            end else begin
              r_next.sh = {r_reg.sh[6:0], 1'b0};
              r_next.oe = ~r_reg.sh[6];
              r_next.cnt = r_reg.cnt + 4'h1;
            end
          end
        end
        SP_MACK: begin
          // Pointer moves only at the master's acknowledge
          if (scl_rise) begin
            if (!r_reg.sda_s2) begin
              r_next.ptr = r_reg.ptr + 3'h1;
            end else begin
              r_next.st = SP_IDLE;
            end
          end else if (scl_fall) begin
            r_next.st = SP_TX;
            r_next.sh = rd_data;
            r_next.oe = ~rd_data[7];
            r_next.cnt = 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_reg <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
                 sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
                 st: SP_IDLE, ph: PH_ADDR, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = r_reg.oe;
  assign reg_ptr = r_reg.ptr;
  assign wr_stb = r_reg.wr_stb;
  assign wr_data = r_reg.wr_data;
  assign rd_active = (r_reg.st == SP_TX) || (r_reg.st == SP_MACK);
endmodule

/* dv/rtc_core_properties.sv */
// Bus and pin checks at the ports of the BCD timekeeper
`timescale 1ns/1ps
module rtc_core_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pins
  input wire logic osc_pin,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic test_level_out,
  input wire logic test_level_oe
);
  // ----------------------------------------
  // Clocks since the bus clock last fell
  // ----------------------------------------
  logic scl_q;
  logic [3:0] low_cnt;
  always_ff @(posedge core_clk) begin
    scl_q <= scl_in;
    if (sys_rst) begin
      low_cnt <= 4'hF;
    end else if (scl_q && !scl_in) begin
      low_cnt <= 4'h0;
    end else if (low_cnt != 4'hF) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking dclk @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  property p_open_drain;
    !sda_out && !test_level_out;
  endproperty
  property p_reset_level;
    $fell(sys_rst) |-> !test_level_oe && !sda_oe;
  endproperty
  property p_drive_scl_low;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  property p_release_scl_low;
    $fell(sda_oe) |-> !scl_in;
  endproperty
  property p_stable_scl_high;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  // Synchroniser lag puts every change a few clocks after the fall
  property p_change_after_fall;
    $changed(sda_oe) |-> low_cnt <= 4'hA;
  endproperty
  property p_stop_idle;
    s_stop |=> !sda_oe [*8];
  endproperty
  property p_start_quiet;
    s_start |=> !sda_oe [*8];
  endproperty
  property p_drive_stands;
    $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin driven high");
  a_reset_level: assert property (p_reset_level)
    else $error("pin pulled after reset");
  a_drive_scl_low: assert property (p_drive_scl_low)
    else $error("data pulled while clock high");
  a_release_scl_low: assert property (p_release_scl_low)
    else $error("data released while clock high");
  a_stable_scl_high: assert property (p_stable_scl_high)
    else $error("data moved while clock high");
  a_change_after_fall: assert property (p_change_after_fall)
    else $error("data moved late after clock fall");
  a_stop_idle: assert property (p_stop_idle)
    else $error("data driven after stop");
  a_start_quiet: assert property (p_start_quiet)
    else $error("data driven after start");
  a_drive_stands: assert property (p_drive_stands)
    else $error("data bit too short");
endmodule

bind rtc_core rtc_core_properties chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .osc_pin(osc_pin),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .test_level_out(test_level_out),
  .test_level_oe(test_level_oe)
);

/* dv/i2c_host_model.sv */
// Bus master model driving the two-wire register port
`timescale 1ns/1ps
module i2c_host_model (
  // Clock
  input wire logic core_clk,
  // Bus wires, both pulled up
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  // Six clocks a phase keeps each clock level above four core clocks
  localparam int HALF = 6;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic gap();
    repeat (HALF) @(posedge core_clk);
  endtask
  // Also serves as repeated start
  task automatic start();
    gap();
    sda_drv <= 1'b1;
    gap();
    scl <= 1'b1;
    gap();
    sda_drv <= 1'b0;
    gap();
    scl <= 1'b0;
  endtask
  task automatic stop();
    gap();
    sda_drv <= 1'b0;
    gap();
    scl <= 1'b1;
    gap();
    sda_drv <= 1'b1;
    gap();
  endtask
  // Data only changes while the bus clock is low
  task automatic bit_io(input logic b, output logic r);
    gap();
    sda_drv <= b;
    gap();
    scl <= 1'b1;
    gap();
    r = sda_wire;
    scl <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack_out);
  endtask
endmodule

/* dv/bcd_rtc_with_calibration_test.sv */
// Self-checking bench of the BCD real-time clock
`timescale 1ns/1ps
module bcd_rtc_with_calibration_test;
  import rtc_pkg::*;
  localparam int LIMIT = 200;
  localparam logic [7:0] WAVE = 8'(2 * OSC_HZ / (2 * TEST_HZ));
  logic core_clk;
  logic sys_rst;
  logic osc_pin = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic test_level_out;
  logic test_level_oe;
  logic [7:0] exp_q[$];
  logic [7:0] got;
  event got_ev;
  int error_cnt;
  int checked;
  logic [31:0] rng;
  logic [7:0] burst [9] = '{8'hD9, 8'h59, 8'hA3, 8'h07, 8'h31,
                            8'h12, 8'h99, 8'h25, 8'hD9};
  logic [7:0] roll [6] = '{8'h00, 8'hC0, 8'h01, 8'h01, 8'h01, 8'h00};
  // ----------------------------------------
  // Design, bus master and wire
  // ----------------------------------------
  assign sda_in = sda_drv & ~sda_oe;
  rtc_core #(.HOLD_CYCLES(50), .SLAVE_ADDR(SLAVE_ADDR_DEF)) dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .osc_pin(osc_pin),
    .scl_in(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .test_level_out(test_level_out),
    .test_level_oe(test_level_oe)
  );
  i2c_host_model m (
    .core_clk(core_clk),
    .sda_wire(sda_in),
    .scl(scl),
    .sda_drv(sda_drv)
  );
  // ----------------------------------------
  // Clock, crystal and scoreboard
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever begin
      #25 core_clk = ~core_clk;
    end
  end
  // Crystal runs fast so one second fits in the run
  always @(posedge core_clk) begin
    osc_pin <= ~osc_pin;
  end
  initial begin
    forever begin
      @(got_ev);
      checked++;
      if (got !== exp_q[0]) begin
        error_cnt++;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp_q[0]);
      end
      exp_q.pop_front();
    end
  end
  initial begin
    repeat (95000) @(posedge core_clk);
    error_cnt++;
    test_done();
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic test_done();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic seen(input logic [7:0] g, input logic [7:0] e);
    exp_q.push_back(e);
    got = g;
    ->got_ev;
  endtask
  // ----------------------------------------
  // Register access
  // ----------------------------------------
  task automatic put(input logic [7:0] b);
    logic [7:0] r;
    logic a;
    m.xfer(b, 1'b1, r, a);
    seen({7'h00, a}, 8'h00);
  endtask
  task automatic get(input logic last, output logic [7:0] v);
    logic a;
    m.xfer(8'hFF, last, v, a);
  endtask
  task automatic rd(input logic [7:0] e, input logic last);
    logic [7:0] v;
    get(last, v);
    seen(v, e);
  endtask
  task automatic sel(input logic [2:0] a, input logic rw);
    m.start();
    put({SLAVE_ADDR_DEF, 1'b0});
    put({5'h00, a});
    if (rw) begin
      m.start();
      put({SLAVE_ADDR_DEF, 1'b1});
    end
  endtask
  task automatic wr1(input logic [2:0] a, input logic [7:0] d);
    sel(a, 1'b0);
    put(d);
    m.stop();
  endtask
  // Clocks between two pin changes, LIMIT when the pin is frozen
  task automatic wave_gap(output int n);
    logic p;
    for (int k = 0; k < 2; k++) begin
      p = test_level_oe;
      n = 0;
      while (test_level_oe === p && n < LIMIT) begin
        @(posedge core_clk);
        n++;
      end
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    logic [7:0] v;
    sys_rst = 1'b1;
    rng = xs(32'h0053);
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    seen({7'h00, test_level_oe}, 8'h00);
    sel(ADDR_CTRL, 1'b1);
    rd(CTRL_RST, 1'b1);
    m.stop();
    wr1(ADDR_SEC, 8'h80);
    wr1(ADDR_SEC, 8'h00);
    sel(ADDR_SEC, 1'b0);
    put(8'hD9);
    put({rng[7], 7'h59});
    put(8'hA3);
    put({rng[7:3], 3'h7});
    put({rng[7:6], 6'h31});
    put({rng[7:5], 5'h12});
    put(8'h99);
    put(8'h25);
    put(8'hD9);
    m.stop();
    sel(ADDR_SEC, 1'b1);
    foreach (burst[i]) begin
      rd(burst[i], 1'(i == 8));
    end
    m.stop();
    seen({7'h00, test_level_oe}, 8'h01);
    m.start();
    put({SLAVE_ADDR_DEF, 1'b1});
    rd(8'hD9, 1'b1);
    m.stop();
    wr1(ADDR_CTRL, 8'h40);
    wave_gap(n);
    seen(n[7:0], 8'(LIMIT));
    wr1(ADDR_SEC, 8'h59);
    wave_gap(n);
    seen(n[7:0], WAVE);
    wr1(ADDR_CTRL, 8'h5F);
    wave_gap(n);
    seen(n[7:0], WAVE);
    wr1(ADDR_CTRL, 8'h80);
    seen({7'h00, test_level_oe}, 8'h00);
    wr1(ADDR_CTRL, 8'h00);
    seen({7'h00, test_level_oe}, 8'h01);
    v = 8'h59;
    for (int k = 0; k < LIMIT && v === 8'h59; k++) begin
      m.start();
      put({SLAVE_ADDR_DEF, 1'b1});
      get(1'b1, v);
      m.stop();
    end
    seen(v, 8'h00);
    sel(ADDR_MIN, 1'b1);
    foreach (roll[i]) begin
      rd(roll[i], 1'(i == 5));
    end
    m.stop();
    repeat (4) @(posedge core_clk);
    test_done();
  end
endmodule
